// File: inc/adcsq_pkg.sv
// constants and carriers of the sample sequencer control block
package adcsq_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_RUN     = 12'h000;
  localparam logic [11:0] OFF_RAW     = 12'h004;
  localparam logic [11:0] OFF_GATE    = 12'h008;
  localparam logic [11:0] OFF_ISC     = 12'h00c;
  localparam logic [11:0] OFF_OVF     = 12'h010;
  localparam logic [11:0] OFF_TSEL    = 12'h014;
  localparam logic [11:0] OFF_UNF     = 12'h018;
  localparam logic [11:0] OFF_PRIO    = 12'h020;
  localparam logic [11:0] OFF_SWST    = 12'h028;
  localparam logic [11:0] OFF_AVG     = 12'h030;
  localparam logic [11:0] OFF_SEQ     = 12'h040;
  localparam logic [11:0] OFF_SEQ_END = 12'h0c0;
  // offsets inside one 32-byte sequencer block
  localparam logic [4:0]  SUB_SRC     = 5'h00;
  localparam logic [4:0]  SUB_CTL     = 5'h04;
  localparam logic [4:0]  SUB_QUEUE   = 5'h08;
  localparam logic [4:0]  SUB_QSTAT   = 5'h0c;
  // reset values, masks and limits
  localparam logic [15:0] PRIO_RST    = 16'h3210;
  localparam logic [15:0] PRIO_MASK   = 16'h3333;
  localparam logic [2:0]  AVG_LOG_MAX = 3'h6;
  // control nibble fields
  localparam int          CTL_DIFF    = 0;
  localparam int          CTL_END     = 1;
  localparam int          CTL_IE      = 2;
  localparam int          CTL_TEMP    = 3;
  // queue status fields
  localparam int          QST_TAIL    = 0;
  localparam int          QST_HEAD    = 4;
  localparam int          QST_EMPTY   = 8;
  localparam int          QST_FULL    = 12;
  // trigger source codes
  localparam logic [3:0]  TRIG_SW     = 4'h0;
  localparam logic [3:0]  TRIG_EXT    = 4'h4;
  localparam logic [3:0]  TRIG_ALWAYS = 4'hf;
  // steps per sequencer, equal to its queue depth
  localparam logic [3:0][3:0] SEQ_SIZE = {4'h1, 4'h4, 4'h4, 4'h8};
  // converter clock derived from pclk
  localparam int          PCLK_KHZ    = 125000;
  localparam int          ADC_KHZ     = 16667;
  localparam int          ADC_DIV     = (PCLK_KHZ + ADC_KHZ - 1) / ADC_KHZ;
  localparam logic [2:0]  ADC_DIV_LAST = 3'(ADC_DIV - 1);

  typedef enum logic [1:0] {FSM_IDLE, FSM_START, FSM_WAIT} adcsq_fsm_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } adcsq_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } adcsq_apb_rsp_t;

  typedef struct packed {
    logic       start;
    logic [2:0] pos;
    logic [2:0] neg;
    logic       diff;
    logic       temp;
  } adcsq_conv_req_t;

  typedef struct packed {
    logic       done;
    logic [9:0] result;
  } adcsq_conv_rsp_t;
endpackage : adcsq_pkg

// File: hw/adcsq_fifo.sv
// circular result queue of one sequencer
`timescale 1ns/1ps
`default_nettype none
module adcsq_fifo #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // fill side
  input  wire logic       push,
  input  wire logic [9:0] push_data,
  // drain side
  input  wire logic       pop,
  output logic [9:0]      pop_data,
  // status
  output logic [3:0]      head,
  output logic [3:0]      tail,
  output logic            full,
  output logic            empty
);
  typedef struct packed {
    logic [DEPTH-1:0][9:0] mem;
    logic [3:0]            head;
    logic [3:0]            tail;
    logic [3:0]            cnt;
  } adcsq_fifo_st_t;

  adcsq_fifo_st_t s_q;
  adcsq_fifo_st_t s_d;

  function automatic logic [3:0] wrap(input logic [3:0] p);
    wrap = (p == 4'(DEPTH - 1)) ? 4'h0 : p + 4'h1;
  endfunction : wrap

  assign pop_data = s_q.mem[s_q.tail];
  assign head     = s_q.head;
  assign tail     = s_q.tail;
  assign full     = s_q.cnt == 4'(DEPTH);
  assign empty    = s_q.cnt == 4'h0;

  always_comb begin
    s_d = s_q;
    // a push into a full queue is dropped
    if (push && !full) begin
      s_d.mem[s_q.head] = push_data;
      s_d.head          = wrap(s_q.head);
    end
    if (pop && !empty) begin
      s_d.tail = wrap(s_q.tail);
    end
    s_d.cnt = s_q.cnt + 4'(push && !full) - 4'(pop && !empty);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule : adcsq_fifo
`default_nettype wire

// File: hw/adcsq_ctrl.sv
// sample sequencer control: register slave, trigger arbiter, step engine
`timescale 1ns/1ps
`default_nettype none
module adcsq_ctrl (
  // clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // register bus
  input  wire adcsq_pkg::adcsq_apb_req_t   apb_i,
  output adcsq_pkg::adcsq_apb_rsp_t        apb_o,
  // external trigger lines
  input  wire logic [3:0]                  trig_i,
  // converter core
  output adcsq_pkg::adcsq_conv_req_t       conv_o,
  input  wire adcsq_pkg::adcsq_conv_rsp_t  conv_i,
  // interrupt
  output logic                             irq_o
);
  typedef struct packed {
    logic [3:0]                 sequencer_run_bits;
    logic [3:0]                 irq_gate;
    logic [3:0]                 raw_irq_bits;
    logic [3:0]                 ovf;
    logic [3:0]                 unf;
    logic [15:0]                trig_sel;
    logic [15:0]                prio;
    logic [2:0]                 avg_log;
    logic [3:0][31:0]           step_source_select;
    logic [3:0][31:0]           step_control;
    logic [3:0]                 pend;
    adcsq_pkg::adcsq_fsm_t      fsm;
    logic [1:0]                 seq;
    logic [2:0]                 step;
    logic [5:0]                 avg_cnt;
    logic [15:0]                acc;
    logic [2:0]                 div;
    logic [3:0]                 trig_m;
    logic [3:0]                 trig_s;
    logic [3:0]                 trig_p;
    adcsq_pkg::adcsq_apb_rsp_t  rsp;
    adcsq_pkg::adcsq_conv_req_t conv;
    logic                       irq;
  } adcsq_ctrl_st_t;

  adcsq_ctrl_st_t   s_q;
  adcsq_ctrl_st_t   s_d;
  logic [3:0][9:0]  f_data;
  logic [3:0][3:0]  f_head;
  logic [3:0][3:0]  f_tail;
  logic [3:0]       f_full;
  logic [3:0]       f_empty;
  logic [3:0]       f_push;
  logic [3:0]       f_pop;
  logic [9:0]       push_val;
  logic [3:0]       raw_set;
  logic [3:0]       nib_src;
  logic [3:0]       nib_ctl;
  logic             tick;
  logic             g_found;
  logic [1:0]       g_idx;
  logic             g_valid;
  logic             better;
  logic             avg_done;
  logic             step_last;
  logic             wr_isc;

  // lowest priority value wins, lower index breaks a tie
  function automatic logic [2:0] pick(input logic [3:0] cand, input logic [15:0] prio);
    logic [2:0] r;
    r = 3'h0;
    for (int lvl = 3; lvl >= 0; lvl--) begin
      for (int n = 3; n >= 0; n--) begin
        if (cand[n] && prio[4*n +: 2] == 2'(lvl)) begin
          r = {1'b1, 2'(n)};
        end
      end
    end
    pick = r;
  endfunction : pick

  for (genvar g = 0; g < 4; g++) begin : gen_queue
    adcsq_fifo #(
      .DEPTH(int'(adcsq_pkg::SEQ_SIZE[g]))
    ) u_queue (
      .pclk     (pclk),
      .presetn  (presetn),
      .push     (f_push[g]),
      .push_data(push_val),
      .pop      (f_pop[g]),
      .pop_data (f_data[g]),
      .head     (f_head[g]),
      .tail     (f_tail[g]),
      .full     (f_full[g]),
      .empty    (f_empty[g])
    );
  end

  always_comb begin
    logic        setup;
    logic        wr;
    logic        rd;
    logic [11:0] soff;
    logic        in_seq;
    logic [1:0]  sidx;
    logic [4:0]  sub;
    logic [3:0]  sw_go;
    logic [3:0]  ext_edge;
    logic [3:0]  new_trig;
    logic [3:0]  grant;
    logic [5:0]  avg_last;
    logic [15:0] acc_n;
    setup    = apb_i.psel && !apb_i.penable;
    wr       = apb_i.psel && apb_i.penable && s_q.rsp.pready && apb_i.pwrite;
    rd       = apb_i.psel && apb_i.penable && s_q.rsp.pready && !apb_i.pwrite;
    soff     = apb_i.paddr - adcsq_pkg::OFF_SEQ;
    in_seq   = apb_i.paddr >= adcsq_pkg::OFF_SEQ && apb_i.paddr < adcsq_pkg::OFF_SEQ_END;
    sidx     = soff[6:5];
    sub      = soff[4:0];
    sw_go    = (wr && apb_i.paddr == adcsq_pkg::OFF_SWST) ? apb_i.pwdata[3:0] : 4'h0;
    ext_edge = s_q.trig_s & ~s_q.trig_p;
    new_trig = 4'h0;
    grant    = 4'h0;
    avg_last = 6'((7'h1 << s_q.avg_log) - 7'h1);
    acc_n    = s_q.acc + 16'(conv_i.result);
    s_d      = s_q;
    f_pop    = 4'h0;
    f_push   = 4'h0;
    push_val = 10'h000;
    raw_set  = 4'h0;
    wr_isc   = wr && apb_i.paddr == adcsq_pkg::OFF_ISC;
    nib_src  = s_q.step_source_select[s_q.seq][{s_q.step, 2'b00} +: 4];
    nib_ctl  = s_q.step_control[s_q.seq][{s_q.step, 2'b00} +: 4];
    avg_done = s_q.avg_cnt == avg_last;
    step_last = nib_ctl[adcsq_pkg::CTL_END] ||
                (4'(s_q.step) + 4'h1 == adcsq_pkg::SEQ_SIZE[s_q.seq]);

    // converter rate strobe
    tick  = s_q.div == adcsq_pkg::ADC_DIV_LAST;
    s_d.div = tick ? 3'h0 : s_q.div + 3'h1;

    // register answer: ready in the first access cycle
    s_d.rsp.pready  = setup;
    s_d.rsp.pslverr = 1'b0;
    if (setup) begin
      s_d.rsp.prdata = 32'h0;
      case (apb_i.paddr)
        adcsq_pkg::OFF_RUN:  s_d.rsp.prdata = {28'h0, s_q.sequencer_run_bits};
        adcsq_pkg::OFF_RAW:  s_d.rsp.prdata = {28'h0, s_q.raw_irq_bits};
        adcsq_pkg::OFF_GATE: s_d.rsp.prdata = {28'h0, s_q.irq_gate};
        adcsq_pkg::OFF_ISC:  s_d.rsp.prdata = {28'h0, s_q.raw_irq_bits & s_q.irq_gate};
        adcsq_pkg::OFF_OVF:  s_d.rsp.prdata = {28'h0, s_q.ovf};
        adcsq_pkg::OFF_UNF:  s_d.rsp.prdata = {28'h0, s_q.unf};
        adcsq_pkg::OFF_TSEL: s_d.rsp.prdata = {16'h0, s_q.trig_sel};
        adcsq_pkg::OFF_PRIO: s_d.rsp.prdata = {16'h0, s_q.prio};
        adcsq_pkg::OFF_SWST: s_d.rsp.prdata = 32'h0;
        adcsq_pkg::OFF_AVG:  s_d.rsp.prdata = {29'h0, s_q.avg_log};
        default: begin
          if (in_seq) begin
            case (sub)
              adcsq_pkg::SUB_SRC:   s_d.rsp.prdata = s_q.step_source_select[sidx];
              adcsq_pkg::SUB_CTL:   s_d.rsp.prdata = s_q.step_control[sidx];
              adcsq_pkg::SUB_QUEUE: s_d.rsp.prdata = {22'h0, f_data[sidx]};
              adcsq_pkg::SUB_QSTAT: begin
                s_d.rsp.prdata = (32'(f_tail[sidx]) << adcsq_pkg::QST_TAIL) |
                                 (32'(f_head[sidx]) << adcsq_pkg::QST_HEAD) |
                                 (32'(f_empty[sidx]) << adcsq_pkg::QST_EMPTY) |
                                 (32'(f_full[sidx]) << adcsq_pkg::QST_FULL);
              end
              default: s_d.rsp.pslverr = 1'b1;
            endcase
          end else begin
            s_d.rsp.pslverr = 1'b1;
          end
        end
      endcase
    end

    // register writes at the access edge
    if (wr) begin
      case (apb_i.paddr)
        adcsq_pkg::OFF_RUN:  s_d.sequencer_run_bits = apb_i.pwdata[3:0];
        adcsq_pkg::OFF_GATE: s_d.irq_gate = apb_i.pwdata[3:0];
        adcsq_pkg::OFF_ISC:  s_d.raw_irq_bits = s_q.raw_irq_bits & ~apb_i.pwdata[3:0];
        adcsq_pkg::OFF_OVF:  s_d.ovf = s_q.ovf & ~apb_i.pwdata[3:0];
        adcsq_pkg::OFF_UNF:  s_d.unf = s_q.unf & ~apb_i.pwdata[3:0];
        adcsq_pkg::OFF_TSEL: s_d.trig_sel = apb_i.pwdata[15:0];
        adcsq_pkg::OFF_PRIO: s_d.prio = apb_i.pwdata[15:0] & adcsq_pkg::PRIO_MASK;
        adcsq_pkg::OFF_AVG: begin
          s_d.avg_log = (apb_i.pwdata[2:0] > adcsq_pkg::AVG_LOG_MAX) ?
                        adcsq_pkg::AVG_LOG_MAX : apb_i.pwdata[2:0];
        end
        default: begin
          if (in_seq && sub == adcsq_pkg::SUB_SRC) begin
            s_d.step_source_select[sidx] = apb_i.pwdata;
          end else if (in_seq && sub == adcsq_pkg::SUB_CTL) begin
            s_d.step_control[sidx] = apb_i.pwdata;
          end
        end
      endcase
    end

    // queue pop on a data read
    if (rd && in_seq && sub == adcsq_pkg::SUB_QUEUE) begin
      f_pop[sidx] = 1'b1;
      if (f_empty[sidx]) begin
        s_d.unf[sidx] = 1'b1;
      end
    end

    // trigger lines: two-stage sync, then edge
    s_d.trig_m = trig_i;
    s_d.trig_s = s_q.trig_m;
    s_d.trig_p = s_q.trig_s;
    for (int n = 0; n < 4; n++) begin
      case (s_q.trig_sel[4*n +: 4])
        adcsq_pkg::TRIG_SW:     new_trig[n] = sw_go[n];
        adcsq_pkg::TRIG_EXT:    new_trig[n] = ext_edge[n];
        adcsq_pkg::TRIG_ALWAYS: new_trig[n] = 1'b1;
        default:                new_trig[n] = 1'b0;
      endcase
    end

    // arbitration
    {g_found, g_idx} = pick(s_q.pend & s_q.sequencer_run_bits, s_q.prio);
    g_valid = s_q.fsm == adcsq_pkg::FSM_IDLE && tick && g_found;
    better  = 1'b0;
    for (int n = 0; n < 4; n++) begin
      if (s_q.pend[n] && s_q.sequencer_run_bits[n] &&
          s_q.prio[4*n +: 2] < s_q.prio[{g_idx, 2'b00} +: 2]) begin
        better = 1'b1;
      end
    end

    // step engine
    s_d.conv.start = 1'b0;
    case (s_q.fsm)
      adcsq_pkg::FSM_IDLE: begin
        if (g_valid) begin
          grant[g_idx] = 1'b1;
          s_d.seq      = g_idx;
          s_d.step     = 3'h0;
          s_d.avg_cnt  = 6'h00;
          s_d.acc      = 16'h0000;
          s_d.fsm      = adcsq_pkg::FSM_START;
        end
      end
      adcsq_pkg::FSM_START: begin
        if (tick) begin
          s_d.conv.start = 1'b1;
          s_d.conv.temp  = nib_ctl[adcsq_pkg::CTL_TEMP];
          s_d.conv.diff  = nib_ctl[adcsq_pkg::CTL_DIFF];
          if (nib_ctl[adcsq_pkg::CTL_DIFF]) begin
            s_d.conv.pos = {nib_src[1:0], 1'b0};
            s_d.conv.neg = {nib_src[1:0], 1'b1};
          end else begin
            s_d.conv.pos = nib_src[2:0];
            s_d.conv.neg = nib_src[2:0];
          end
          s_d.fsm = adcsq_pkg::FSM_WAIT;
        end
      end
      adcsq_pkg::FSM_WAIT: begin
        if (conv_i.done) begin
          s_d.acc     = acc_n;
          s_d.avg_cnt = s_q.avg_cnt + 6'h01;
          s_d.fsm     = adcsq_pkg::FSM_START;
          if (avg_done) begin
            push_val          = 10'(acc_n >> s_q.avg_log);
            f_push[s_q.seq]   = 1'b1;
            raw_set[s_q.seq]  = nib_ctl[adcsq_pkg::CTL_IE];
            if (f_full[s_q.seq]) begin
              s_d.ovf[s_q.seq] = 1'b1;
            end
            s_d.acc     = 16'h0000;
            s_d.avg_cnt = 6'h00;
            s_d.step    = s_q.step + 3'h1;
            if (step_last) begin
              s_d.fsm = adcsq_pkg::FSM_IDLE;
            end
          end
        end
      end
      default: s_d.fsm = adcsq_pkg::FSM_IDLE;
    endcase

    // new events win over clears
    s_d.pend         = ((s_q.pend & ~grant) | new_trig) & s_q.sequencer_run_bits;
    s_d.raw_irq_bits = s_d.raw_irq_bits | raw_set;
    s_d.irq          = |(s_d.raw_irq_bits & s_d.irq_gate);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q      <= '0;
      s_q.prio <= adcsq_pkg::PRIO_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_o  = s_q.rsp;
  assign conv_o = s_q.conv;
  assign irq_o  = s_q.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence last_step_done;
    s_q.fsm == adcsq_pkg::FSM_WAIT && conv_i.done && avg_done && step_last;
  endsequence
  sequence ie_step_done;
    s_q.fsm == adcsq_pkg::FSM_WAIT && conv_i.done && avg_done && nib_ctl[adcsq_pkg::CTL_IE];
  endsequence

  end_stops_a: assert property (last_step_done |=> s_q.fsm == adcsq_pkg::FSM_IDLE)
    else $error("sequence ran past its last step");
  step_irq_a: assert property (ie_step_done |=> s_q.raw_irq_bits[$past(s_q.seq)])
    else $error("step interrupt not raised");
  irq_gate_a: assert property (irq_o == |(s_q.raw_irq_bits & s_q.irq_gate))
    else $error("interrupt output disagrees with gated raw bits");
  isc_clear_a: assert property (wr_isc && raw_set == 4'h0 |=>
    (s_q.raw_irq_bits & $past(apb_i.pwdata[3:0])) == 4'h0)
    else $error("write one did not clear interrupt");
  grant_run_a: assert property (g_valid |-> s_q.sequencer_run_bits[g_idx] && s_q.pend[g_idx])
    else $error("grant to an idle or disabled sequencer");
  grant_prio_a: assert property (g_valid |-> !better)
    else $error("grant skipped a higher priority sequencer");
  div_tick_a: assert property (conv_o.start |-> $past(s_q.div) == adcsq_pkg::ADC_DIV_LAST)
    else $error("conversion started off the converter rate");
  diff_pair_a: assert property (conv_o.start && conv_o.diff |->
    !conv_o.pos[0] && conv_o.neg == conv_o.pos + 3'h1)
    else $error("bad differential pair");
  ovf_flag_a: assert property (|(f_push & f_full) |=> |(s_q.ovf & $past(f_push)))
    else $error("overflow not flagged");
  unf_flag_a: assert property (|(f_pop & f_empty) |=> |(s_q.unf & $past(f_pop)))
    else $error("underflow not flagged");
  start_wait_a: assert property (conv_o.start |-> s_q.fsm == adcsq_pkg::FSM_WAIT ##1 !conv_o.start)
    else $error("start pulse not followed by wait");
endmodule : adcsq_ctrl
`default_nettype wire

// File: tb/adcsq_conv_model.sv
// converter core model answering each start after a set latency
`timescale 1ns/1ps
`default_nettype none
module adcsq_conv_model (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // converter link
  input  wire adcsq_pkg::adcsq_conv_req_t req,
  output adcsq_pkg::adcsq_conv_rsp_t      rsp,
  // answer delay in cycles
  input  wire logic [4:0]                 lat
);
  logic [5:0] cnt_q;

  // result encodes the selected inputs so each step can be told apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 6'h00;
      rsp   <= '0;
    end else begin
      rsp.done   <= 1'b0;
      rsp.result <= ~rsp.result;
      if (req.start) begin
        cnt_q <= {1'b0, lat} + 6'h01;
      end else if (cnt_q == 6'h01) begin
        cnt_q      <= 6'h00;
        rsp.done   <= 1'b1;
        rsp.result <= {req.temp, req.diff, req.pos, req.neg, 2'h1};
      end else if (cnt_q != 6'h00) begin
        cnt_q <= cnt_q - 6'h01;
      end
    end
  end
endmodule : adcsq_conv_model
`default_nettype wire

// File: tb/test_adc_sample_sequencer_control.sv
// self-checking bench of the sample sequencer control block
`timescale 1ns/1ps
`default_nettype none
module test_adc_sample_sequencer_control;
  logic                       pclk    = 1'b0;
  logic                       presetn = 1'b0;
  adcsq_pkg::adcsq_apb_req_t  apb_q   = '0;
  adcsq_pkg::adcsq_apb_rsp_t  apb_s;
  adcsq_pkg::adcsq_conv_req_t cv_q;
  adcsq_pkg::adcsq_conv_rsp_t cv_s;
  logic [3:0]                 trig_q  = 4'h0;
  logic [4:0]                 lat_q   = 5'h08;
  logic                       irq;
  logic                       serr;
  logic [31:0]                rdat;
  logic [31:0]                srcw;
  logic [3:0]                 a;
  logic [3:0]                 b;
  int                         mismatches = 0;
  int                         cmp_count  = 0;

  always #4 pclk = ~pclk;

  adcsq_ctrl u_dut (
    .pclk    (pclk),
    .presetn (presetn),
    .apb_i   (apb_q),
    .apb_o   (apb_s),
    .trig_i  (trig_q),
    .conv_o  (cv_q),
    .conv_i  (cv_s),
    .irq_o   (irq)
  );

  adcsq_conv_model u_core (
    .pclk    (pclk),
    .presetn (presetn),
    .req     (cv_q),
    .rsp     (cv_s),
    .lat     (lat_q)
  );

  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb_q <= '{1'b1, 1'b0, wr, ad, d};
    @(posedge pclk);
    apb_q.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_s.pready !== 1'b1 && n < 40);
    if (apb_s.pready !== 1'b1) mismatches++;
    rdat = apb_s.prdata;
    serr = apb_s.pslverr;
    apb_q <= '0;
  endtask : xfer

  // reads until every bit of m is set, bounded
  task automatic poll(input logic [11:0] ad, input logic [31:0] m);
    int n;
    n = 0;
    do begin
      xfer(1'b0, ad, 32'h0);
      n++;
    end while ((rdat & m) !== m && n < 300);
    if ((rdat & m) !== m) mismatches++;
  endtask : poll

  task automatic wait_start();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (cv_q.start !== 1'b1 && n < 200);
    if (cv_q.start !== 1'b1) mismatches++;
  endtask : wait_start

  function automatic logic [11:0] sa(input int n, input logic [4:0] sub);
    return adcsq_pkg::OFF_SEQ + 12'(n * 32) + {7'h00, sub};
  endfunction : sa

  // queue word expected for one step
  function automatic logic [31:0] er(input logic [3:0] s, input logic [3:0] c);
    logic       df;
    logic [2:0] p;
    logic [2:0] q;
    df = c[adcsq_pkg::CTL_DIFF];
    p  = df ? {s[1:0], 1'b0} : s[2:0];
    q  = df ? {s[1:0], 1'b1} : s[2:0];
    return {22'h000000, c[adcsq_pkg::CTL_TEMP], df, p, q, 2'h1};
  endfunction : er

  initial begin
    #200us;
    mismatches++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h1994));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, adcsq_pkg::OFF_PRIO, 32'h0);
    chk("prio reset", rdat, 32'h3210);
    xfer(1'b0, 12'h3fc, 32'h0);
    chk("unmapped", {serr, rdat[30:0]}, 32'h80000000);
    // sequencer zero: repeated input, temp sensor, a pair, last at fifth step
    for (int i = 0; i < 8; i++) srcw[4*i +: 4] = 4'($urandom_range(0, 7));
    srcw[7:4]  = srcw[3:0];
    srcw[11:8] = 4'($urandom_range(0, 3));
    lat_q <= 5'($urandom_range(8, 31));
    xfer(1'b1, sa(0, adcsq_pkg::SUB_SRC), srcw);
    xfer(1'b1, sa(0, adcsq_pkg::SUB_CTL), 32'h000601c0);
    xfer(1'b1, adcsq_pkg::OFF_GATE, 32'h1);
    xfer(1'b1, adcsq_pkg::OFF_RUN, 32'h1);
    xfer(1'b1, adcsq_pkg::OFF_SWST, 32'h1);
    poll(adcsq_pkg::OFF_RAW, 32'h1);
    chk("irq on", {31'h0, irq}, 32'h1);
    xfer(1'b0, adcsq_pkg::OFF_ISC, 32'h0);
    chk("masked status", rdat, 32'h1);
    xfer(1'b1, adcsq_pkg::OFF_ISC, 32'h1);
    xfer(1'b0, adcsq_pkg::OFF_RAW, 32'h0);
    chk("raw cleared", rdat, 32'h0);
    poll(adcsq_pkg::OFF_RAW, 32'h1);
    xfer(1'b1, adcsq_pkg::OFF_ISC, 32'h0);
    xfer(1'b0, adcsq_pkg::OFF_ISC, 32'h0);
    chk("zero write", rdat, 32'h1);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, sa(0, adcsq_pkg::SUB_QUEUE), 32'h0);
      chk("queue0 data", rdat, er(srcw[4*i +: 4], 4'(32'h000601c0 >> (4*i))));
    end
    xfer(1'b0, sa(0, adcsq_pkg::SUB_QSTAT), 32'h0);
    chk("queue0 empty", rdat & 32'h1100, 32'h0100);
    xfer(1'b0, sa(0, adcsq_pkg::SUB_QUEUE), 32'h0);
    xfer(1'b0, adcsq_pkg::OFF_UNF, 32'h0);
    chk("underflow", rdat, 32'h1);
    xfer(1'b1, adcsq_pkg::OFF_UNF, 32'h1);
    xfer(1'b1, adcsq_pkg::OFF_ISC, 32'h1);
    xfer(1'b0, adcsq_pkg::OFF_UNF, 32'h0);
    chk("underflow clr", {rdat[30:0], irq}, 32'h0);
    // disabled sequencer one ignores a software start
    xfer(1'b1, adcsq_pkg::OFF_SWST, 32'h2);
    repeat (40) @(posedge pclk);
    xfer(1'b0, sa(1, adcsq_pkg::SUB_QSTAT), 32'h0);
    chk("idle queue1", rdat & 32'h0100, 32'h0100);
    // sequencer two above sequencer one, started together
    a = 4'($urandom_range(0, 7));
    b = a ^ 4'($urandom_range(1, 7));
    lat_q <= 5'($urandom_range(0, 31));
    xfer(1'b1, sa(1, adcsq_pkg::SUB_SRC), {28'h0, a});
    xfer(1'b1, sa(1, adcsq_pkg::SUB_CTL), 32'h6);
    xfer(1'b1, sa(2, adcsq_pkg::SUB_SRC), {28'h0, b});
    xfer(1'b1, sa(2, adcsq_pkg::SUB_CTL), 32'h6);
    xfer(1'b1, adcsq_pkg::OFF_PRIO, 32'h3012);
    xfer(1'b1, adcsq_pkg::OFF_RUN, 32'h6);
    xfer(1'b1, adcsq_pkg::OFF_SWST, 32'h6);
    wait_start();
    chk("first grant", {29'h0, cv_q.pos}, {29'h0, b[2:0]});
    wait_start();
    chk("second grant", {29'h0, cv_q.pos}, {29'h0, a[2:0]});
    poll(adcsq_pkg::OFF_RAW, 32'h6);
    chk("gated irq", {31'h0, irq}, 32'h0);
    xfer(1'b0, sa(2, adcsq_pkg::SUB_QUEUE), 32'h0);
    chk("queue2 data", rdat, er(b, 4'h6));
    xfer(1'b0, sa(1, adcsq_pkg::SUB_QUEUE), 32'h0);
    chk("queue1 data", rdat, er(a, 4'h6));
    // always trigger on sequencer three overruns its one-deep queue
    xfer(1'b1, sa(3, adcsq_pkg::SUB_SRC), {28'h0, a});
    xfer(1'b1, sa(3, adcsq_pkg::SUB_CTL), 32'h6);
    xfer(1'b1, adcsq_pkg::OFF_TSEL, 32'hf000);
    xfer(1'b1, adcsq_pkg::OFF_RUN, 32'h8);
    poll(adcsq_pkg::OFF_OVF, 32'h8);
    xfer(1'b1, adcsq_pkg::OFF_RUN, 32'h0);
    xfer(1'b0, sa(3, adcsq_pkg::SUB_QSTAT), 32'h0);
    chk("queue3 full", rdat & 32'h1100, 32'h1000);
    xfer(1'b0, sa(3, adcsq_pkg::SUB_QUEUE), 32'h0);
    chk("queue3 data", rdat, er(a, 4'h6));
    xfer(1'b0, adcsq_pkg::OFF_RAW, 32'h0);
    chk("raw bits", rdat, 32'he);
    // external edge starts sequencer one, four conversions averaged
    xfer(1'b1, adcsq_pkg::OFF_AVG, 32'h7);
    xfer(1'b0, adcsq_pkg::OFF_AVG, 32'h0);
    chk("avg clamp", rdat, 32'h6);
    xfer(1'b1, adcsq_pkg::OFF_AVG, 32'h2);
    xfer(1'b1, adcsq_pkg::OFF_ISC, 32'hf);
    xfer(1'b1, adcsq_pkg::OFF_TSEL, 32'h0040);
    xfer(1'b1, adcsq_pkg::OFF_RUN, 32'h2);
    trig_q <= 4'h2;
    poll(adcsq_pkg::OFF_RAW, 32'h2);
    xfer(1'b0, sa(1, adcsq_pkg::SUB_QUEUE), 32'h0);
    chk("ext avg data", rdat, er(a, 4'h6));
    xfer(1'b0, sa(1, adcsq_pkg::SUB_QSTAT), 32'h0);
    chk("ext one entry", rdat & 32'h1100, 32'h0100);
    wrap_up();
  end
endmodule : test_adc_sample_sequencer_control
`default_nettype wire
